// File: core/amp_page0_config_regs.sv
`timescale 1ns/1ps
module amp_page0_config_regs
   import amp_cfg_pkg::*;
#(
   parameter int WAIT_CYCLES_0 = WAIT_CYC_0,
   parameter int WAIT_CYCLES_1 = WAIT_CYC_1,
   parameter int WAIT_CYCLES_2 = WAIT_CYC_2,
   parameter int WAIT_CYCLES_3 = WAIT_CYC_3,
   parameter int RETRY_CYCLES = RETRY_CYC
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // register port
   input wire logic [7:0] regPage,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic regHit,
   // neighbouring configuration, same clock
   input wire logic classdSyncEn,
   input wire logic rate44kFamily,
   // pins and fault detectors, asynchronous
   input wire logic shutdown_pin_n,
   input wire logic overcurrentFault,
   input wire logic overtempFault,
   // configuration fields
   output logic [7:0] outputStageCfg,
   output logic [7:0] supplyFilterCfg,
   output logic [7:0] recordPathCfg,
   output logic [7:0] protectionCfg,
   output logic [7:0] shutdownBusCfg,
   // decoded controls
   output logic spreadActive,
   output logic volumeRampActive,
   output logic playbackDcBypass,
   output logic recordDcBypass,
   output logic dcBlockRateScaled,
   output logic sarFilterOn,
   // shutdown and protection
   output logic ampShutdown,
   output logic faultShutdown,
   output logic retryPulse
);

   logic [4:0] wrSel;
   logic pageZero;
   logic [7:0] next_regRdata;
   logic next_regHit;

   // access only counts while page 0 is selected
   assign pageZero = (regPage == PAGE_ZERO);

   always_comb begin
      wrSel = 5'h00;
      if (regWrite && pageZero) begin
         case (regAddr)
            OFS_OUTPUT_STAGE: wrSel = 5'h01;
            OFS_SUPPLY_FILTER: wrSel = 5'h02;
            OFS_RECORD_PATH: wrSel = 5'h04;
            OFS_PROTECTION: wrSel = 5'h08;
            OFS_SHUTDOWN_BUS: wrSel = 5'h10;
            default: wrSel = 5'h00;
         endcase
      end
   end

   // one storage register per address, reserved bits masked off
   cfg_byte_reg #(
      .RESET_VAL(RST_OUTPUT_STAGE),
      .WR_MASK(WMASK_OUTPUT_STAGE),
      .SELF_CLEAR(SCLR_NONE)
   ) u_output_stage_config (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wrEn(wrSel[0]),
      .wrData(regWdata),
      .value(outputStageCfg)
   );

   cfg_byte_reg #(
      .RESET_VAL(RST_SUPPLY_FILTER),
      .WR_MASK(WMASK_SUPPLY_FILTER),
      .SELF_CLEAR(SCLR_NONE)
   ) u_supply_and_filter_config (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wrEn(wrSel[1]),
      .wrData(regWdata),
      .value(supplyFilterCfg)
   );

   cfg_byte_reg #(
      .RESET_VAL(RST_RECORD_PATH),
      .WR_MASK(WMASK_RECORD_PATH),
      .SELF_CLEAR(SCLR_NONE)
   ) u_record_path_config (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wrEn(wrSel[2]),
      .wrData(regWdata),
      .value(recordPathCfg)
   );

   cfg_byte_reg #(
      .RESET_VAL(RST_PROTECTION),
      .WR_MASK(WMASK_PROTECTION),
      .SELF_CLEAR(SCLR_NONE)
   ) u_protection_config (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wrEn(wrSel[3]),
      .wrData(regWdata),
      .value(protectionCfg)
   );

   // redetect bit reads 1 for one cycle, which is the re-detect strobe
   cfg_byte_reg #(
      .RESET_VAL(RST_SHUTDOWN_BUS),
      .WR_MASK(WMASK_SHUTDOWN_BUS),
      .SELF_CLEAR(SCLR_SHUTDOWN_BUS)
   ) u_shutdown_and_bus_config (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wrEn(wrSel[4]),
      .wrData(regWdata),
      .value(shutdownBusCfg)
   );

   // read path: unmapped or other page answers 00h with regHit low
   always_comb begin
      next_regRdata = regRdata;
      next_regHit = regHit;
      if (regRead) begin
         next_regHit = pageZero;
         next_regRdata = 8'h00;
         if (pageZero) begin
            case (regAddr)
               OFS_OUTPUT_STAGE: next_regRdata = outputStageCfg;
               OFS_SUPPLY_FILTER: next_regRdata = supplyFilterCfg;
               OFS_RECORD_PATH: next_regRdata = recordPathCfg;
               OFS_PROTECTION: next_regRdata = protectionCfg;
               OFS_SHUTDOWN_BUS: next_regRdata = shutdownBusCfg;
               default: begin
                  next_regRdata = 8'h00;
                  next_regHit = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         regRdata <= 8'h00;
         regHit <= 1'b0;
      end else if (ce) begin
         regRdata <= next_regRdata;
         regHit <= next_regHit;
      end
   end

   // decoded controls are registered so every output leaves a flop
   logic next_spreadActive;
   logic next_volumeRampActive;
   logic next_playbackDcBypass;
   logic next_recordDcBypass;
   logic next_dcBlockRateScaled;
   logic next_sarFilterOn;

   always_comb begin
      next_spreadActive = supplyFilterCfg[SPREAD_BIT] & ~classdSyncEn;
      next_volumeRampActive = (shutdownBusCfg[RAMP_MSB:RAMP_LSB] == RAMP_ON);
      // reserved blocker code 7 is treated as bypass, the safe choice
      next_playbackDcBypass = (supplyFilterCfg[DCB_MSB:DCB_LSB] == DCB_BYPASS) ||
         (supplyFilterCfg[DCB_MSB:DCB_LSB] == DCB_RESERVED);
      next_recordDcBypass = (recordPathCfg[DCB_MSB:DCB_LSB] == DCB_BYPASS) ||
         (recordPathCfg[DCB_MSB:DCB_LSB] == DCB_RESERVED);
      next_dcBlockRateScaled = rate44kFamily;
      next_sarFilterOn = (supplyFilterCfg[SAR_MSB:SAR_LSB] != SAR_OFF);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         spreadActive <= 1'b0;
         volumeRampActive <= 1'b0;
         playbackDcBypass <= 1'b0;
         recordDcBypass <= 1'b0;
         dcBlockRateScaled <= 1'b0;
         sarFilterOn <= 1'b0;
      end else if (ce) begin
         spreadActive <= next_spreadActive;
         volumeRampActive <= next_volumeRampActive;
         playbackDcBypass <= next_playbackDcBypass;
         recordDcBypass <= next_recordDcBypass;
         dcBlockRateScaled <= next_dcBlockRateScaled;
         sarFilterOn <= next_sarFilterOn;
      end
   end

   // two-flop synchronisers for the asynchronous inputs
   logic [2:0] syncMeta;
   logic [2:0] syncOut;
   logic pinLow;
   logic ocFault;
   logic otFault;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         syncMeta <= 3'h1;
         syncOut <= 3'h1;
      end else if (ce) begin
         syncMeta <= {overtempFault, overcurrentFault, shutdown_pin_n};
         syncOut <= syncMeta;
      end
   end

   assign pinLow = ~syncOut[0];
   assign ocFault = syncOut[1];
   assign otFault = syncOut[2];

   // shutdown sequencing on the shutdown pin
   shut_state_t shutState;
   shut_state_t next_shutState;
   logic [TIMER_W-1:0] shutTimer;
   logic [TIMER_W-1:0] next_shutTimer;
   logic [TIMER_W-1:0] waitLoad;
   logic next_ampShutdown;

   always_comb begin
      case (shutdownBusCfg[WAIT_MSB:WAIT_LSB])
         2'h0: waitLoad = TIMER_W'(WAIT_CYCLES_0 - 1);
         2'h1: waitLoad = TIMER_W'(WAIT_CYCLES_1 - 1);
         2'h2: waitLoad = TIMER_W'(WAIT_CYCLES_2 - 1);
         default: waitLoad = TIMER_W'(WAIT_CYCLES_3 - 1);
      endcase
   end

   // reserved styles fall back to the timeout path, never a hard cut
   always_comb begin
      next_shutState = shutState;
      next_shutTimer = shutTimer;
      case (shutState)
         SD_ACTIVE: begin
            if (pinLow) begin
               if (shutdownBusCfg[STYLE_MSB:STYLE_LSB] == STYLE_IMMEDIATE) begin
                  next_shutState = SD_OFF;
               end else begin
                  next_shutState = SD_WAIT;
                  next_shutTimer = waitLoad;
               end
            end
         end
         SD_WAIT: begin
            if (!pinLow) begin
               next_shutState = SD_ACTIVE;
            end else if (shutTimer == '0) begin
               next_shutState = SD_OFF;
            end else begin
               next_shutTimer = shutTimer - 1'b1;
            end
         end
         SD_OFF: begin
            if (!pinLow) begin
               next_shutState = SD_ACTIVE;
            end
         end
         default: next_shutState = SD_ACTIVE;
      endcase
      next_ampShutdown = (next_shutState == SD_OFF);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         shutState <= SD_ACTIVE;
         shutTimer <= '0;
         ampShutdown <= 1'b0;
      end else if (ce) begin
         shutState <= next_shutState;
         shutTimer <= next_shutTimer;
         ampShutdown <= next_ampShutdown;
      end
   end

   // fault shutdown with optional timed retry per fault type
   prot_state_t protState;
   prot_state_t next_protState;
   logic [TIMER_W-1:0] retryTimer;
   logic [TIMER_W-1:0] next_retryTimer;
   logic next_faultShutdown;
   logic next_retryPulse;
   logic retryAllowed;

   // both faults at once retry only when both types permit it
   assign retryAllowed = (~ocFault | protectionCfg[OC_RETRY_BIT]) &
      (~otFault | protectionCfg[OT_RETRY_BIT]);

   always_comb begin
      next_protState = protState;
      next_retryTimer = retryTimer;
      next_retryPulse = 1'b0;
      case (protState)
         PROT_RUN: begin
            if (ocFault || otFault) begin
               next_protState = retryAllowed ? PROT_WAIT : PROT_LATCHED;
               next_retryTimer = TIMER_W'(RETRY_CYCLES - 1);
            end
         end
         PROT_WAIT: begin
            if (!retryAllowed) begin
               next_protState = PROT_LATCHED;
            end else if (retryTimer == '0) begin
               next_protState = PROT_RUN;
               next_retryPulse = 1'b1;
            end else begin
               next_retryTimer = retryTimer - 1'b1;
            end
         end
         PROT_LATCHED: begin
            // only a hardware shutdown clears a latched fault
            if (pinLow) begin
               next_protState = PROT_RUN;
            end
         end
         default: next_protState = PROT_RUN;
      endcase
      next_faultShutdown = (next_protState != PROT_RUN);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         protState <= PROT_RUN;
         retryTimer <= '0;
         faultShutdown <= 1'b0;
         retryPulse <= 1'b0;
      end else if (ce) begin
         protState <= next_protState;
         retryTimer <= next_retryTimer;
         faultShutdown <= next_faultShutdown;
         retryPulse <= next_retryPulse;
      end
   end

   // checks on the register and control behaviour
   supply_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && wrSel[0] |=> outputStageCfg[SUPPLY_SEL_MSB:SUPPLY_SEL_LSB] ==
         $past(regWdata[SUPPLY_SEL_MSB:SUPPLY_SEL_LSB]))
      else $error("supply select not stored");

   rail_pullup_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && wrSel[1] |=> supplyFilterCfg[LOW_RAIL_BIT] == $past(regWdata[LOW_RAIL_BIT]) &&
         supplyFilterCfg[IRQ_PU_BIT] == $past(regWdata[IRQ_PU_BIT]))
      else $error("rail source or pull-up not stored");

   spread_priority_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && classdSyncEn |=> !spreadActive)
      else $error("spread active while sync mode on");

   level_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && wrSel[0] |=> outputStageCfg[LEVEL_MSB:LEVEL_LSB] ==
         $past(regWdata[LEVEL_MSB:LEVEL_LSB]) && !outputStageCfg[0])
      else $error("level field wrong or reserved bit moved");

   reserved_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      recordPathCfg[7:4] == 4'h4 && protectionCfg[7:6] == 2'h0 && protectionCfg[1:0] == 2'h0)
      else $error("reserved bits changed");

   redetect_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && shutdownBusCfg[REDETECT_BIT] && !wrSel[4] |=> !shutdownBusCfg[REDETECT_BIT])
      else $error("redetect bit did not self clear");

   immediate_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && shutState == SD_ACTIVE && pinLow &&
         shutdownBusCfg[STYLE_MSB:STYLE_LSB] == STYLE_IMMEDIATE |=> ampShutdown)
      else $error("immediate shutdown missed");

   timeout_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      shutState == SD_WAIT && shutTimer != '0 |-> !ampShutdown)
      else $error("shutdown before timeout");

   retry_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && protState == PROT_WAIT && retryTimer == '0 && retryAllowed
         |=> retryPulse && !faultShutdown)
      else $error("retry did not release");

   no_retry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && protState == PROT_RUN && otFault && !protectionCfg[OT_RETRY_BIT]
         |=> protState == PROT_LATCHED && faultShutdown)
      else $error("fault without retry not latched");

   ramp_decode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce && shutdownBusCfg[RAMP_MSB:RAMP_LSB] == RAMP_OFF |=> !volumeRampActive)
      else $error("ramp active while disabled");

endmodule

// File: core/cfg_byte_reg.sv
`timescale 1ns/1ps
module cfg_byte_reg
   import amp_cfg_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hff,
   parameter logic [7:0] SELF_CLEAR = 8'h00
) (
   // clock and control
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // write side
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   // stored value
   output logic [7:0] value
);

   logic [7:0] next_value;

   // self-clearing bits drop first, so a fresh write of 1 still wins
   always_comb begin
      next_value = value & ~SELF_CLEAR;
      if (wrEn) begin
         next_value = (next_value & ~WR_MASK) | (wrData & WR_MASK);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         value <= RESET_VAL;
      end else if (ce) begin
         value <= next_value;
      end
   end

endmodule

// File: shared/amp_cfg_pkg.sv
// Notes on behaviour
// - class_d_supply_select picks output stage supply: 00/01/10/11 as four supply modes.
// - supply register bit 7 picks low rail source: 0 external, 1 internal.
// - irq_pin_pullup_en 1 enables interrupt pin pull-up; 0 disables, reset 0.
// - spread spectrum on by default; clock sync mode overrides it.
// - sar_filter_cutoff: 0 off, 1 300 kHz, 2 150 kHz, 3 50 kHz.
// - playback DC blocker: 0 bypass, 1..6 cut-offs, 7 reserved, reset 1.
// - at 44.1/88.2 kHz rates, blocker cut-offs scale down by 1.0884.
// - record DC blocker uses the playback encoding, reset code 1.
// - overcurrent_retry_en 1 retries after timer following over-current shutdown.
// - overtemp_retry_en 1 retries after timer; 0 stays shut down.
// - post_filter_feedback_en: 0 feedback from outputs, 1 from sense pins.
// - shutdown_style 0 waits timeout, 1 immediate; wait codes 2/4/6/23.8 ms.
// - volume_ramp_setting 0 ramps, 3 disables ramp, 1 and 2 reserved.
// - writing 1 to address_redetect re-detects bus address, then self clears.
package amp_cfg_pkg;

   // register offsets on page 0
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_STAGE = 8'h03;
   localparam logic [7:0] OFS_SUPPLY_FILTER = 8'h04;
   localparam logic [7:0] OFS_RECORD_PATH = 8'h05;
   localparam logic [7:0] OFS_PROTECTION = 8'h06;
   localparam logic [7:0] OFS_SHUTDOWN_BUS = 8'h07;
   localparam int NUM_REGS = 5;

   // reset values
   localparam logic [7:0] RST_OUTPUT_STAGE = 8'h28;
   localparam logic [7:0] RST_SUPPLY_FILTER = 8'h21;
   localparam logic [7:0] RST_RECORD_PATH = 8'h41;
   localparam logic [7:0] RST_PROTECTION = 8'h00;
   localparam logic [7:0] RST_SHUTDOWN_BUS = 8'h20;

   // writable bits; reserved bits are left out and keep reset value
   localparam logic [7:0] WMASK_OUTPUT_STAGE = 8'hfe;
   localparam logic [7:0] WMASK_SUPPLY_FILTER = 8'hff;
   localparam logic [7:0] WMASK_RECORD_PATH = 8'h0f;
   localparam logic [7:0] WMASK_PROTECTION = 8'h3c;
   localparam logic [7:0] WMASK_SHUTDOWN_BUS = 8'hff;
   localparam logic [7:0] SCLR_SHUTDOWN_BUS = 8'h01;
   localparam logic [7:0] SCLR_NONE = 8'h00;

   // field positions
   localparam int SUPPLY_SEL_MSB = 7;
   localparam int SUPPLY_SEL_LSB = 6;
   localparam int LEVEL_MSB = 5;
   localparam int LEVEL_LSB = 1;
   localparam int LOW_RAIL_BIT = 7;
   localparam int IRQ_PU_BIT = 6;
   localparam int SPREAD_BIT = 5;
   localparam int SAR_MSB = 4;
   localparam int SAR_LSB = 3;
   localparam int DCB_MSB = 2;
   localparam int DCB_LSB = 0;
   localparam int FOLDBACK_BIT = 3;
   localparam int OC_RETRY_BIT = 5;
   localparam int OT_RETRY_BIT = 4;
   localparam int FEEDBACK_BIT = 3;
   localparam int SAFE_BIT = 2;
   localparam int STYLE_MSB = 7;
   localparam int STYLE_LSB = 6;
   localparam int WAIT_MSB = 5;
   localparam int WAIT_LSB = 4;
   localparam int RAMP_MSB = 3;
   localparam int RAMP_LSB = 2;
   localparam int BCAST_BIT = 1;
   localparam int REDETECT_BIT = 0;

   // codes
   localparam logic [1:0] STYLE_TIMEOUT = 2'h0;
   localparam logic [1:0] STYLE_IMMEDIATE = 2'h1;
   localparam logic [1:0] RAMP_ON = 2'h0;
   localparam logic [1:0] RAMP_OFF = 2'h3;
   localparam logic [2:0] DCB_BYPASS = 3'h0;
   localparam logic [2:0] DCB_RESERVED = 3'h7;
   localparam logic [1:0] SAR_OFF = 2'h0;
   localparam logic [4:0] LEVEL_MAX = 5'h14;

   // timing
   localparam int CLK_KHZ = 200000;
   localparam int WAIT_MS_0 = 2;
   localparam int WAIT_MS_1 = 4;
   localparam int WAIT_MS_2 = 6;
   localparam real WAIT_MS_3 = 23.8;
   localparam int WAIT_CYC_0 = WAIT_MS_0 * CLK_KHZ;
   localparam int WAIT_CYC_1 = WAIT_MS_1 * CLK_KHZ;
   localparam int WAIT_CYC_2 = WAIT_MS_2 * CLK_KHZ;
   localparam int WAIT_CYC_3 = int'(WAIT_MS_3 * CLK_KHZ);
   localparam int RETRY_MS = 1;
   localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;
   localparam int TIMER_W = 23;

   typedef enum logic [1:0] {
      SD_ACTIVE = 2'b00,
      SD_WAIT = 2'b01,
      SD_OFF = 2'b10
   } shut_state_t;

   typedef enum logic [1:0] {
      PROT_RUN = 2'b00,
      PROT_WAIT = 2'b01,
      PROT_LATCHED = 2'b10
   } prot_state_t;

endpackage

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb
   import amp_cfg_pkg::*;
();
   // short timer figures keep the run brief; windows below derive from them
   localparam int W[4] = '{8, 12, 16, 20};
   localparam int RT = 10;
   localparam logic [7:0] RV[5] = '{8'h28, 8'h21, 8'h41, 8'h00, 8'h20};
   localparam logic [7:0] WM[5] = '{8'hfe, 8'hff, 8'h0f, 8'h3c, 8'hff};
   localparam logic [7:0] PT[3] = '{8'hff, 8'h00, 8'h5a};

   // stimulus and observed signals
   logic sys_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1;
   logic [7:0] regPage = 8'h00, regAddr = 8'h00, regWdata = 8'h00;
   logic regWrite = 1'b0, regRead = 1'b0, classdSyncEn = 1'b0, rate44kFamily = 1'b0;
   logic shutdown_pin_n = 1'b1, overcurrentFault = 1'b0, overtempFault = 1'b0;
   logic [7:0] regRdata, outputStageCfg, supplyFilterCfg, recordPathCfg;
   logic [7:0] protectionCfg, shutdownBusCfg, e;
   logic regHit, spreadActive, volumeRampActive, playbackDcBypass, recordDcBypass;
   logic dcBlockRateScaled, sarFilterOn, ampShutdown, faultShutdown, retryPulse, seen;
   int n_mismatch = 0, checks_done = 0, n, s, k;

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   amp_page0_config_regs #(
      .WAIT_CYCLES_0(W[0]), .WAIT_CYCLES_1(W[1]), .WAIT_CYCLES_2(W[2]),
      .WAIT_CYCLES_3(W[3]), .RETRY_CYCLES(RT)
   ) amp_page0_config_regs_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
      .regPage(regPage), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
      .classdSyncEn(classdSyncEn), .rate44kFamily(rate44kFamily),
      .shutdown_pin_n(shutdown_pin_n), .overcurrentFault(overcurrentFault),
      .overtempFault(overtempFault), .outputStageCfg(outputStageCfg),
      .supplyFilterCfg(supplyFilterCfg), .recordPathCfg(recordPathCfg),
      .protectionCfg(protectionCfg), .shutdownBusCfg(shutdownBusCfg),
      .spreadActive(spreadActive), .volumeRampActive(volumeRampActive),
      .playbackDcBypass(playbackDcBypass), .recordDcBypass(recordDcBypass),
      .dcBlockRateScaled(dcBlockRateScaled), .sarFilterOn(sarFilterOn),
      .ampShutdown(ampShutdown), .faultShutdown(faultShutdown), .retryPulse(retryPulse)
   );

   // helpers to index outputs in loops
   function automatic logic [7:0] cfg(input int i);
      case (i)
         0: return outputStageCfg;
         1: return supplyFilterCfg;
         2: return recordPathCfg;
         3: return protectionCfg;
         default: return shutdownBusCfg;
      endcase
   endfunction

   function automatic logic pick(input int w);
      case (w)
         0: return ampShutdown;
         1: return faultShutdown;
         default: return retryPulse;
      endcase
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] v, input logic [7:0] x);
      checks_done++;
      if (v !== x) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, x, v);
      end
   endtask

   // one write: strobe held over exactly one taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask

   // read data and hit flag are registered, so look just after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic h);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      chk("read data", regRdata, x);
      chk("read hit", {7'h0, regHit}, {7'h0, h});
   endtask

   // bounded wait for a level; running out ends the run
   task automatic wait_for(input int w, input logic lv, input int lim, output int c);
      c = 0;
      // settle first, so an output launched by this edge is never raced
      #1;
      while (pick(w) !== lv) begin
         if (c == lim) begin
            n_mismatch++;
            $display("[ERR] wait %0d expected %b seen timeout", w, lv);
            close_out();
         end else begin
            @(posedge sys_clk);
            #1;
            c++;
         end
      end
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      for (int i = 0; i < 5; i++) begin
         chk("reset cfg", cfg(i), RV[i]);
         rd(8'(i + 3), RV[i], 1'b1);
      end
      // reserved bits keep reset value, redetect bit reads back cleared
      for (int p = 0; p < 3; p++) begin
         for (int i = 0; i < 5; i++) begin
            e = ((PT[p] & WM[i]) | (RV[i] & ~WM[i])) & ((i == 4) ? 8'hfe : 8'hff);
            wr(8'(i + 3), PT[p]);
            rd(8'(i + 3), e, 1'b1);
         end
      end
      // write and read in one cycle: the read sees the old contents
      @(posedge sys_clk);
      regAddr <= 8'h05;
      regWdata <= 8'h03;
      regWrite <= 1'b1;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      #1;
      chk("old read", regRdata, 8'h4a);
      chk("new cfg", recordPathCfg, 8'h43);
      wr(8'h07, 8'h01);
      #1;
      chk("redetect set", shutdownBusCfg, 8'h01);
      @(posedge sys_clk);
      #1;
      chk("redetect clr", shutdownBusCfg, 8'h00);
      // other page, unmapped offsets and a frozen clock enable refuse access
      @(posedge sys_clk);
      regPage <= 8'h01;
      wr(8'h03, 8'h00);
      rd(8'h03, 8'h00, 1'b0);
      @(posedge sys_clk);
      regPage <= 8'h00;
      rd(8'h08, 8'h00, 1'b0);
      rd(8'h02, 8'h00, 1'b0);
      @(posedge sys_clk);
      ce <= 1'b0;
      wr(8'h03, 8'h00);
      @(posedge sys_clk);
      ce <= 1'b1;
      rd(8'h03, 8'h5a, 1'b1);
      // every SAR, DC blocker and ramp field code reaches its decoded control; the spread bit stays set
      for (int c = 0; c < 8; c++) begin
         wr(8'h03, {c[1:0], 5'h14, 1'b0});
         wr(8'h04, {3'b001, c[1:0], c[2:0]});
         wr(8'h05, {5'h08, c[2:0]});
         wr(8'h07, {4'h0, c[1:0], 2'h0});
         classdSyncEn <= c[0];
         rate44kFamily <= c[1];
         repeat (3) @(posedge sys_clk);
         #1;
         chk("supply sel", {6'h0, outputStageCfg[7:6]}, {6'h0, c[1:0]});
         chk("level", {3'h0, outputStageCfg[5:1]}, 8'h14);
         chk("spread", {7'h0, spreadActive}, {7'h0, !c[0]});
         chk("sar", {7'h0, sarFilterOn}, {7'h0, c[1:0] != 0});
         chk("pb bypass", {7'h0, playbackDcBypass}, {7'h0, c == 0 || c == 7});
         chk("rec bypass", {7'h0, recordDcBypass}, {7'h0, c == 0 || c == 7});
         chk("ramp", {7'h0, volumeRampActive}, {7'h0, c[1:0] == 0});
         chk("rate", {7'h0, dcBlockRateScaled}, {7'h0, c[1]});
      end
      // shutdown pin: immediate style, timeout style per wait code, then reserved style
      for (int j = 0; j < 6; j++) begin
         s = (j == 0) ? 1 : ((j == 5) ? 2 : 0);
         k = (j == 0 || j == 5) ? 0 : j - 1;
         wr(8'h07, {s[1:0], k[1:0], 4'h0});
         @(posedge sys_clk);
         shutdown_pin_n <= 1'b0;
         wait_for(0, 1'b1, 40, n);
         chk("sd delay", {7'h0, (s == 1) ? n <= 5 : (n >= W[k] && n <= W[k] + 6)}, 8'h01);
         @(posedge sys_clk);
         shutdown_pin_n <= 1'b1;
         wait_for(0, 1'b0, 10, n);
      end
      // faults: timed retry when enabled, latched until pin low otherwise
      for (int f = 0; f < 2; f++) begin
         wr(8'h06, f ? 8'h10 : 8'h20);
         @(posedge sys_clk);
         {overcurrentFault, overtempFault} <= f ? 2'b01 : 2'b10;
         wait_for(1, 1'b1, 8, n);
         @(posedge sys_clk);
         {overcurrentFault, overtempFault} <= 2'b00;
         wait_for(2, 1'b1, RT + 6, n);
         chk("retry time", {7'h0, n >= RT - 3 && n <= RT + 2}, 8'h01);
         chk("fault clr", {7'h0, faultShutdown}, 8'h00);
         @(posedge sys_clk);
         #1;
         chk("pulse", {7'h0, retryPulse}, 8'h00);
         wr(8'h06, 8'h00);
         @(posedge sys_clk);
         {overcurrentFault, overtempFault} <= f ? 2'b01 : 2'b10;
         wait_for(1, 1'b1, 8, n);
         @(posedge sys_clk);
         {overcurrentFault, overtempFault} <= 2'b00;
         seen = 1'b0;
         repeat (RT + 8) begin
            @(posedge sys_clk);
            #1;
            seen = seen | retryPulse;
         end
         chk("no retry", {7'h0, seen}, 8'h00);
         chk("latched", {7'h0, faultShutdown}, 8'h01);
         @(posedge sys_clk);
         shutdown_pin_n <= 1'b0;
         wait_for(1, 1'b0, 10, n);
         @(posedge sys_clk);
         shutdown_pin_n <= 1'b1;
         wait_for(0, 1'b0, 60, n);
      end
      close_out();
   end
endmodule
